//--- common/eewc_pkg.sv
/*
 * shared constants and carrier types for the host-side write cycle controller
 * assumes a 200 MHz core clock and the slow (-200) speed grade of the memory
 */
package eewc_pkg;
   // clock period in picoseconds
   localparam int unsigned CLK_PS           = 5000;
   // times in their own units, for the slow grade
   localparam int unsigned MAX_PROGRAM_MS   = 20;
   localparam int unsigned WRITE_START_NS   = 250;
   localparam int unsigned GUARD_SETUP_US   = 200;
   localparam int unsigned PULSE_NS         = 350;
   localparam int unsigned ACCESS_NS        = 200;
   // cycle counts, least times rounded up
   // cycles per millisecond first, so the product stays inside 32 bits
   localparam int unsigned MAX_PROGRAM_CYC  = MAX_PROGRAM_MS * ((1000000000 + CLK_PS - 1) / CLK_PS);
   localparam int unsigned WRITE_START_CYC  = (WRITE_START_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int unsigned GUARD_SETUP_CYC  = (GUARD_SETUP_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int unsigned PULSE_CYC        = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int unsigned ACCESS_CYC       = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
   // widths
   localparam int unsigned ADDR_W           = 17;
   localparam int unsigned DATA_W           = 32;
   localparam int unsigned BANK_W           = 2;
   localparam int unsigned CNT_W            = 24;
   localparam int unsigned POLL_BIT         = 7;
   // completion detection modes
   localparam logic [1:0]  DET_WAIT         = 2'h0;
   localparam logic [1:0]  DET_POLL         = 2'h1;
   localparam logic [1:0]  DET_BUSY         = 2'h2;

   // user request
   typedef struct packed {
      logic                write;
      logic                bank;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } eewc_req_type;

   // memory control pins, all active low
   typedef struct packed {
      logic [BANK_W-1:0]   chipEnable_n;
      logic                outputEnable_n;
      logic                writeEnable_n;
      logic                write_guard_n;
   } eewc_ctl_type;
endpackage

//--- hw/eewc_host.sv
/*
 * host controller driving an asynchronous 32-bit eeprom module: reads,
 * single-word writes, and completion detection by waiting, polling or busy pin
 * assumes pins are synchronous to core_clk and a board pull-up on busy
 */
`timescale 1ns/1ps
// Behaviour
// - only one chip enable low at once
// - without detection wait full program time
// - with detection wait start interval then completion
// - guard high setup before any write strobe
module eewc_host
(
   input  wire logic                         core_clk,
   input  wire logic                         rst_n,
   input  wire logic                         reqValid,
   input  wire eewc_pkg::eewc_req_type       req,
   input  wire logic [1:0]                   detectMode,
   input  wire logic                         guardEnable,
   output logic                              reqReady,
   output logic                              rdValid,
   output logic [eewc_pkg::DATA_W-1:0]       rdData,
   output logic                              wrDone,
   output eewc_pkg::eewc_ctl_type            ctl,
   output logic [eewc_pkg::ADDR_W-1:0]       memAddr,
   output logic [eewc_pkg::DATA_W-1:0]       memDataOut,
   output logic                              memDataOe_n,
   input  wire logic [eewc_pkg::DATA_W-1:0]  memDataIn,
   input  wire logic                         busyIn_n
);
   import eewc_pkg::*;

   // one-hot controller states
   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_READ   = 7'h02,
      ST_STROBE = 7'h04,
      ST_START  = 7'h08,
      ST_WAIT   = 7'h10,
      ST_POLL   = 7'h20,
      ST_RECOV  = 7'h40
   } eewc_state_type;

   eewc_state_type     state;      // current state
   logic [CNT_W-1:0]   timer;      // shared phase counter
   logic [CNT_W-1:0]   guardCnt;   // cycles guard has been high
   logic               lastBit7;   // bit 7 of last written data
   logic [1:0]         mode;       // detection mode latched per write
   logic               wrBank;     // bank of the write being polled

   // chip enable decode, only one bank active
   function automatic logic [BANK_W-1:0] bankSel(input logic b);
      bankSel = b ? 2'h1 : 2'h2;
   endfunction

   // guard setup counter, the pin itself is driven by the sequencer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         guardCnt          <= '0;
      end
      else
      begin
         // count setup while guard is driven high
         if (!ctl.write_guard_n)
            guardCnt <= '0;
         else if (guardCnt != CNT_W'(GUARD_SETUP_CYC))
            guardCnt <= guardCnt + 1'b1;
      end
   end

   // main sequencer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state                 <= ST_IDLE;
         timer                 <= '0;
         reqReady              <= 1'b0;
         rdValid               <= 1'b0;
         rdData                <= '0;
         wrDone                <= 1'b0;
         ctl.chipEnable_n      <= '1;
         ctl.outputEnable_n    <= 1'b1;
         ctl.writeEnable_n     <= 1'b1;
         memAddr               <= '0;
         memDataOut            <= '0;
         memDataOe_n           <= 1'b1;
         lastBit7              <= 1'b0;
         mode                  <= DET_WAIT;
         wrBank                <= 1'b0;
         ctl.write_guard_n     <= 1'b0;
      end
      else
      begin
         rdValid <= 1'b0;
         wrDone  <= 1'b0;
         timer   <= timer + 1'b1;
         // guard pin follows its enable in every state
         ctl.write_guard_n <= guardEnable;
         case (state)
            ST_IDLE:
            begin
               // accept only when guard is up and set up
               reqReady <= (guardCnt == CNT_W'(GUARD_SETUP_CYC)) && ctl.write_guard_n;
               if (reqValid && reqReady)
               begin
                  reqReady         <= 1'b0;
                  timer            <= '0;
                  memAddr          <= req.addr;
                  ctl.chipEnable_n <= bankSel(req.bank);
                  if (req.write)
                  begin
                     memDataOut        <= req.data;
                     memDataOe_n       <= 1'b0;
                     lastBit7          <= req.data[POLL_BIT];
                     wrBank            <= req.bank;
                     ctl.writeEnable_n <= 1'b0;
                     mode              <= detectMode;
                     state             <= ST_STROBE;
                  end
                  else
                  begin
                     ctl.outputEnable_n <= 1'b0;
                     state              <= ST_READ;
                  end
               end
            end
            ST_READ:
            begin
               // sample after access time, then standby
               if (timer == CNT_W'(ACCESS_CYC))
               begin
                  rdData             <= memDataIn;
                  rdValid            <= 1'b1;
                  ctl.outputEnable_n <= 1'b1;
                  ctl.chipEnable_n   <= '1;
                  state              <= ST_IDLE;
               end
            end
            ST_STROBE:
            begin
               // data latched on rising write enable
               if (timer == CNT_W'(PULSE_CYC))
               begin
                  ctl.writeEnable_n <= 1'b1;
                  ctl.chipEnable_n  <= '1;
                  memDataOe_n       <= 1'b1;
                  timer             <= '0;
                  state             <= ST_START;
               end
            end
            ST_START:
            begin
               // single word, device starts programming itself
               if (timer == CNT_W'(WRITE_START_CYC))
               begin
                  timer <= '0;
                  state <= (mode == DET_WAIT) ? ST_WAIT : ST_POLL;
               end
            end
            ST_WAIT:
            begin
               // full program time without detection
               if (timer == CNT_W'(MAX_PROGRAM_CYC))
               begin
                  wrDone <= 1'b1;
                  state  <= ST_IDLE;
               end
            end
            ST_POLL:
            begin
               if (mode == DET_BUSY)
               begin
                  // busy released to pull-up ends cycle
                  if (busyIn_n)
                  begin
                     wrDone <= 1'b1;
                     state  <= ST_IDLE;
                  end
               end
               else if (ctl.outputEnable_n)
               begin
                  // open a polling read
                  ctl.chipEnable_n   <= bankSel(wrBank);
                  ctl.outputEnable_n <= 1'b0;
                  timer              <= '0;
               end
               else if (timer == CNT_W'(ACCESS_CYC))
               begin
                  // true bit 7 means done
                  ctl.outputEnable_n <= 1'b1;
                  ctl.chipEnable_n   <= '1;
                  timer              <= '0;
                  if (memDataIn[POLL_BIT] == lastBit7)
                  begin
                     wrDone <= 1'b1;
                     state  <= ST_IDLE;
                  end
                  else
                     state <= ST_RECOV;
               end
               // guard fall aborts
               if (!ctl.write_guard_n)
               begin
                  ctl.outputEnable_n <= 1'b1;
                  ctl.chipEnable_n   <= '1;
                  wrDone             <= 1'b1;
                  state              <= ST_IDLE;
               end
            end
            ST_RECOV:
            begin
               // two idle cycles between polling reads
               timer <= '0;
               state <= ST_POLL;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // never two banks selected
   a_one_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
      $countones(~ctl.chipEnable_n) <= 1)
      else $error("two chip enables low");
   // write strobe only after guard setup
   a_guard_setup: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(ctl.writeEnable_n) |-> $past(guardCnt) == CNT_W'(GUARD_SETUP_CYC))
      else $error("write strobe before guard setup");
   // wait mode completion exactly after program time
   a_wait_full: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == ST_WAIT && timer == CNT_W'(MAX_PROGRAM_CYC)) |=> wrDone && state == ST_IDLE)
      else $error("wait mode finished at wrong time");
   // no access during the first 8 cycles of the start interval
   a_start_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(ctl.writeEnable_n) |-> (ctl.chipEnable_n == '1) [*8])
      else $error("access inside start interval");
   // standby drives no data
   a_standby: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctl.chipEnable_n == '1 |-> memDataOe_n)
      else $error("data driven in standby");
   c_read: cover property (@(posedge core_clk) rdValid);
   c_poll: cover property (@(posedge core_clk) state == ST_RECOV);
   c_done: cover property (@(posedge core_clk) wrDone && mode == DET_BUSY);
   c_wait: cover property (@(posedge core_clk) state == ST_WAIT);
   // wait mode never ends before the full program time
   a_wait_early: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == ST_WAIT && timer != CNT_W'(MAX_PROGRAM_CYC)) |=> !wrDone)
      else $error("wait mode finished early");
endmodule

//--- test/eewc_dev.sv
/* memory model: two banks of four words, self-timed program, bit 7 poll, busy pin
   assumes host pins change on core_clk and a pull-up on the busy line */
`timescale 1ns/1ps
module eewc_dev
#(parameter int PROG = 300)
(
   input  wire logic                        core_clk,
   input  wire eewc_pkg::eewc_ctl_type      ctl,
   input  wire logic [eewc_pkg::ADDR_W-1:0] memAddr,
   input  wire logic [eewc_pkg::DATA_W-1:0] memDataOut,
   output logic [eewc_pkg::DATA_W-1:0]      memDataIn,
   output logic                             busyIn_n
);
   import eewc_pkg::*;
   logic [DATA_W-1:0] mem [2][4];  // stored words
   logic [DATA_W-1:0] pend;        // word being loaded
   logic [DATA_W-1:0] held;        // last value on the data lines
   logic [2:0]        pAt;         // bank and word of the load
   logic              weOld;       // strobe one cycle ago
   int                cnt = 0;     // program cycles left
   wire               sel = ~&ctl.chipEnable_n;
   wire  [2:0]        at = {~ctl.chipEnable_n[0], memAddr[1:0]};
   // load while strobed, program once the strobe ends
   always @(posedge core_clk)
   begin
      weOld <= ctl.writeEnable_n;
      held  <= memDataIn;
      if (!ctl.writeEnable_n && sel)
      begin
         pend <= memDataOut;
         pAt  <= at;
      end
      if (!ctl.write_guard_n)
         cnt <= 0;
      else if (ctl.writeEnable_n && !weOld)
      begin
         mem[pAt[2]][pAt[1:0]] <= pend;
         cnt <= PROG;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // released line is pulled up
   assign busyIn_n = !(cnt > 0);
   // read path, or a toggling pattern when not driven
   always_comb
      if (sel && !ctl.outputEnable_n && ctl.write_guard_n)
         memDataIn = (cnt > 0) ? pend ^ 32'h00000080 : mem[at[2]][at[1:0]];
      else
         memDataIn = ~held;
endmodule

//--- test/tb.sv
/* bench: host controller against the memory model, poll, busy and guard abort
   assumes the model's short program time stands in for the real one */
`timescale 1ns/1ps
module tb;
   import eewc_pkg::*;
   localparam int PROG = 300;  // shortened program time
   logic core_clk = 0, rst_n = 0, reqValid = 0, guardEnable = 0;
   logic reqReady, rdValid, wrDone, memDataOe_n, busyIn_n;
   logic [1:0] detectMode = DET_POLL;
   logic [DATA_W-1:0] rdData, memDataOut, memDataIn, got;
   logic [ADDR_W-1:0] memAddr;
   eewc_req_type req = '0;
   eewc_ctl_type ctl;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   eewc_host DUT (.core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
      .detectMode(detectMode), .guardEnable(guardEnable), .reqReady(reqReady),
      .rdValid(rdValid), .rdData(rdData), .wrDone(wrDone), .ctl(ctl), .memAddr(memAddr),
      .memDataOut(memDataOut), .memDataOe_n(memDataOe_n), .memDataIn(memDataIn),
      .busyIn_n(busyIn_n));
   eewc_dev #(.PROG(PROG)) mdl (.core_clk(core_clk), .ctl(ctl), .memAddr(memAddr),
      .memDataOut(memDataOut), .memDataIn(memDataIn), .busyIn_n(busyIn_n));
   task automatic chk_bit(input logic g, input logic e, input string m);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic chk_word(input logic [DATA_W-1:0] g, e, input string m);
      chk_bit(g === e, 1'b1, m);
   endtask
   task automatic test_done();
      $display("checked %0d, failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // present one request, hold it until taken
   task automatic issue(input logic w, b, input logic [DATA_W-1:0] d, input logic [1:0] m);
      @(negedge core_clk);
      req = '{write: w, bank: b, addr: {16'h0000, b}, data: d};
      detectMode = m;
      reqValid = 1;
      do @(posedge core_clk); while (reqReady !== 1'b1);
      @(negedge core_clk);
      reqValid = 0;
   endtask
   // wait a bounded time for a pulse or level: 0 ready, 1 write done, 2 read valid
   task automatic waitFor(input int which, input int lim, output logic ok);
      ok = 0;
      repeat (lim)
      begin
         @(negedge core_clk);
         if ((which == 0 && reqReady === 1'b1) || (which == 1 && wrDone === 1'b1) ||
             (which == 2 && rdValid === 1'b1))
         begin
            ok = 1;
            got = rdData;
            break;
         end
      end
   endtask
   task automatic t_guard();
      logic ok;
      chk_bit(ctl.write_guard_n, 1'b0, "guard high in reset");
      chk_bit(&ctl.chipEnable_n, 1'b1, "enabled in reset");
      guardEnable = 1;
      repeat (39990) @(negedge core_clk);
      chk_bit(reqReady, 1'b0, "ready too early");
      waitFor(0, 100, ok);
      chk_bit(ok, 1'b1, "never ready");
      $display("t_guard done");
   endtask
   task automatic t_write(input logic b, input logic [DATA_W-1:0] d, input logic [1:0] m);
      logic ok;
      issue(1'b1, b, d, m);
      waitFor(1, PROG + 2000, ok);
      chk_bit(ok, 1'b1, "no write done");
      chk_bit(busyIn_n, 1'b1, "done while busy");
      issue(1'b0, b, '0, m);
      waitFor(2, 100, ok);
      chk_bit(ok, 1'b1, "no read data");
      chk_word(got, d, "read back");
      $display("t_write done");
   endtask
   // wait mode: no completion in the first PROG + 300 cycles after the request is taken, then a mid-run reset
   task automatic t_wait();
      logic ok;
      guardEnable = 1;
      waitFor(0, 40100, ok);
      chk_bit(ok, 1'b1, "not ready after guard setup");
      issue(1'b1, 1'b1, 32'h0F0F0F70, DET_WAIT);
      waitFor(1, PROG + 300, ok);
      chk_bit(ok, 1'b0, "done before program time");
      chk_bit(busyIn_n, 1'b1, "device still busy");
      chk_bit(reqReady, 1'b0, "ready during program wait");
      rst_n = 0;
      @(negedge core_clk);
      chk_bit(&ctl.chipEnable_n & ctl.outputEnable_n & ctl.writeEnable_n & memDataOe_n,
         1'b1, "pins active in reset");
      chk_bit(ctl.write_guard_n | reqReady | wrDone, 1'b0, "guard or ready in reset");
      repeat (2) @(negedge core_clk);
      rst_n = 1;
      repeat (2) @(negedge core_clk);
      chk_bit(ctl.write_guard_n, 1'b1, "guard not back after reset");
      chk_bit(reqReady, 1'b0, "ready before setup after reset");
      $display("t_wait done");
   endtask
   task automatic t_abort();
      logic ok;
      issue(1'b1, 1'b0, 32'h00000055, DET_POLL);
      repeat (200) @(negedge core_clk);
      guardEnable = 0;
      waitFor(1, 50, ok);
      chk_bit(ok, 1'b1, "no abort done");
      repeat (10) @(negedge core_clk);
      chk_bit(ctl.write_guard_n, 1'b0, "guard not low");
      chk_bit(reqReady, 1'b0, "ready with guard low");
      $display("t_abort done");
   endtask
   // pin checks on every cycle out of reset
   always @(negedge core_clk)
      if (rst_n)
      begin
         chk_bit(|ctl.chipEnable_n, 1'b1, "two banks on");
         chk_bit(ctl.writeEnable_n | ctl.write_guard_n, 1'b1, "strobe, guard low");
      end
   initial
   begin
      forever #2.5 core_clk = ~core_clk;
   end
   // hang limit
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fail_count++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
   end
   initial
   begin
      repeat (3) @(negedge core_clk);
      rst_n = 1;
      t_guard();
      t_write(1'b1, 32'h12345687, DET_POLL);
      t_write(1'b0, 32'hA5A5A511, DET_BUSY);
      t_abort();
      t_wait();
      test_done();
   end
endmodule
